// File: hdl/moau_core.sv
// Memory ordering, alignment check and byte-order control of the core's load/store path.
// Functional notes
// - Accesses before order barrier observed first.
// - Order barrier never holds non-memory instructions.
// - Completion barrier waits for all accesses.
// - Nothing executes until completion barrier ends.
// - Fetches resume only after sync barrier.
// - Sync barrier flushes pipeline, synchronises context.
// - Context changes visible to later fetches.
// - Exception and debug events also synchronise.
// - Later accesses wait behind acquire load.
// - Release store waits for earlier accesses.
// - Fetch addresses must be halfword aligned.
// - Unaligned normal access needs main extension.
// - Device accesses fault unless naturally aligned.
// - Acquire/release halfwords fault when unaligned.
// - Trap bit faults unaligned ordinary word accesses.
// - Endian mode picks byte at lowest address.
// - Byte order captured at reset, then fixed.
// - Instruction fetches are always little-endian.
// - Private peripheral bus always little-endian.
// - Non-reordering device accesses stay in order.
module moau_core
	import moau_pkg::*;
#(
	parameter bit MAIN_EXT = 1'b1,
	parameter int CNT_W    = OUT_CNT_W
)
(
	// Clock and reset.
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	// Configuration.
	input  wire logic              big_endian_strap_i,
	input  wire logic              unaligned_trap_bit_i,
	output logic                   endian_be_o,
	// Pipeline request and answer.
	input  wire logic              req_valid_i,
	input  wire moau_op_e          req_op_i,
	input  wire moau_size_e        req_size_i,
	input  wire logic [ADDR_W-1:0] req_addr_i,
	input  wire logic [DATA_W-1:0] req_wdata_i,
	input  wire logic              req_device_i,
	input  wire logic              req_no_reorder_i,
	input  wire logic              req_ppb_i,
	output logic                   req_done_o,
	output logic                   req_fault_o,
	output logic                   fault_hard_o,
	output logic [DATA_W-1:0]      req_rdata_o,
	output logic                   issue_stall_o,
	// Context synchronisation.
	input  wire logic              ctx_busy_i,
	input  wire logic              ctx_event_i,
	output logic                   pipe_flush_o,
	// Instruction fetch.
	input  wire logic              fetch_valid_i,
	input  wire logic [ADDR_W-1:0] fetch_addr_i,
	input  wire logic [DATA_W-1:0] fetch_rdata_i,
	output logic                   fetch_ok_o,
	output logic                   fetch_fault_o,
	output logic                   fetch_hold_o,
	output logic [DATA_W-1:0]      fetch_instr_o,
	// Data bus.
	input  wire logic              bus_gnt_i,
	input  wire logic              bus_rsp_i,
	input  wire logic [DATA_W-1:0] bus_rdata_i,
	output logic                   bus_req_o,
	output logic                   bus_we_o,
	output logic [ADDR_W-1:0]      bus_addr_o,
	output moau_size_e             bus_size_o,
	output logic [DATA_W-1:0]      bus_wdata_o
);

	moau_state_e       state_reg;
	moau_state_e       state_next;
	moau_op_e          op_reg;
	moau_size_e        size_reg;
	logic              ppb_reg;
	logic              endian_be_reg;
	logic              cap_done_reg;
	logic              fence_reg;
	logic              fence_next;
	logic [CNT_W-1:0]  out_cnt_reg;
	logic [CNT_W-1:0]  out_cnt_next;
	logic              req_done_reg;
	logic              req_done_next;
	logic              req_fault_reg;
	logic              req_fault_next;
	logic              fault_hard_reg;
	logic              fault_hard_next;
	logic [DATA_W-1:0] req_rdata_reg;
	logic [DATA_W-1:0] req_rdata_next;
	logic              issue_stall_reg;
	logic              issue_stall_next;
	logic              pipe_flush_reg;
	logic              pipe_flush_next;
	logic              fetch_hold_reg;
	logic              fetch_hold_next;
	logic              fetch_ok_reg;
	logic              fetch_fault_reg;
	logic [DATA_W-1:0] fetch_instr_reg;
	logic              bus_req_reg;
	logic              bus_req_next;
	logic              bus_we_reg;
	logic [ADDR_W-1:0] bus_addr_reg;
	moau_size_e        bus_size_reg;
	logic [DATA_W-1:0] bus_wdata_reg;

	// Request decode.
	wire take       = req_valid_i && (state_reg == ST_IDLE) && !req_done_reg && cap_done_reg;
	wire op_acqrel  = (req_op_i == OP_ACQUIRE_LOAD) || (req_op_i == OP_RELEASE_STORE);
	wire op_store   = (req_op_i == OP_STORE) || (req_op_i == OP_RELEASE_STORE);
	wire op_mem     = (req_op_i == OP_LOAD) || (req_op_i == OP_STORE) || op_acqrel;
	wire reg_store  = (op_reg == OP_STORE) || (op_reg == OP_RELEASE_STORE);
	wire mis_half   = req_addr_i[ADDR_HALF_BIT];
	wire mis_word   = |req_addr_i[WORD_OFS_W-1:0];
	wire misaligned = ((req_size_i == SZ_HALF) && mis_half) || ((req_size_i == SZ_WORD) && mis_word);

	// Alignment checks, all resolved before anything reaches the bus.
	wire flt_hard   = !MAIN_EXT && !req_device_i && misaligned;
	wire flt_device = req_device_i && misaligned;
	wire flt_acqrel = op_acqrel && (req_size_i == SZ_HALF) && mis_half;
	wire flt_trap   = unaligned_trap_bit_i && !op_acqrel && (req_size_i == SZ_WORD) && mis_word;
	wire flt_any    = op_mem && (flt_hard || flt_device || flt_acqrel || flt_trap);

	// Outstanding transfer bookkeeping.
	wire cnt_zero   = (out_cnt_reg == '0);
	wire cnt_full   = &out_cnt_reg;
	wire gnt_fire   = bus_req_reg && bus_gnt_i;
	wire last_rsp   = bus_rsp_i && (out_cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});
	// Waiting for an empty bus is coarser than needed but keeps every ordering case on one path.
	wire must_drain = fence_reg || (req_op_i == OP_RELEASE_STORE) || (req_device_i && req_no_reorder_i) || cnt_full;

	assign out_cnt_next = out_cnt_reg + {{(CNT_W-1){1'b0}}, gnt_fire} - {{(CNT_W-1){1'b0}}, bus_rsp_i};

	// Byte-order converters; the private peripheral bus bypasses swapping.
	moau_swap_if wr_sw ();
	moau_swap_if rd_sw ();

	assign wr_sw.swap_en = endian_be_reg && !req_ppb_i;
	assign wr_sw.size    = req_size_i;
	assign wr_sw.din     = req_wdata_i;
	assign rd_sw.swap_en = endian_be_reg && !ppb_reg;
	assign rd_sw.size    = size_reg;
	assign rd_sw.din     = bus_rdata_i;

	moau_byte_swap u_wr_swap
	(
		.sw (wr_sw.swapper)
	);

	moau_byte_swap u_rd_swap
	(
		.sw (rd_sw.swapper)
	);

	always_comb
	begin
		state_next       = state_reg;
		fence_next       = fence_reg;
		req_done_next    = 1'b0;
		req_fault_next   = 1'b0;
		fault_hard_next  = 1'b0;
		req_rdata_next   = req_rdata_reg;
		issue_stall_next = issue_stall_reg;
		pipe_flush_next  = ctx_event_i;
		fetch_hold_next  = ctx_event_i;
		bus_req_next     = bus_req_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (take)
				begin
					if (req_op_i == OP_NONMEM)
					begin
						req_done_next = 1'b1;
					end
					else if (req_op_i == OP_DATA_ORDER_BARRIER)
					begin
						fence_next    = 1'b1;
						req_done_next = 1'b1;
					end
					else if (req_op_i == OP_DATA_COMPLETION_BARRIER)
					begin
						issue_stall_next = 1'b1;
						state_next       = ST_DRAIN;
					end
					else if (req_op_i == OP_FETCH_SYNC_BARRIER)
					begin
						pipe_flush_next = 1'b1;
						fetch_hold_next = 1'b1;
						state_next      = ST_SYNC;
					end
					else if (flt_any)
					begin
						req_done_next   = 1'b1;
						req_fault_next  = 1'b1;
						fault_hard_next = flt_hard;
					end
					else if (must_drain && !cnt_zero)
					begin
						state_next = ST_DRAIN;
					end
					else
					begin
						bus_req_next = 1'b1;
						fence_next   = 1'b0;
						state_next   = ST_ISSUE;
					end
				end
			end
			ST_DRAIN:
			begin
				if (cnt_zero)
				begin
					if (op_reg == OP_DATA_COMPLETION_BARRIER)
					begin
						req_done_next    = 1'b1;
						issue_stall_next = 1'b0;
						state_next       = ST_IDLE;
					end
					else
					begin
						bus_req_next = 1'b1;
						fence_next   = 1'b0;
						state_next   = ST_ISSUE;
					end
				end
			end
			ST_ISSUE:
			begin
				if (bus_gnt_i)
				begin
					bus_req_next = 1'b0;
					if (reg_store)
					begin
						req_done_next = 1'b1;
						state_next    = ST_IDLE;
					end
					else
					begin
						state_next = ST_RESP;
					end
				end
			end
			ST_RESP:
			begin
				// Answers return in order, so a load ends on the last outstanding one and nothing passes it.
				if (last_rsp)
				begin
					req_rdata_next = rd_sw.dout;
					req_done_next  = 1'b1;
					state_next     = ST_IDLE;
				end
			end
			ST_SYNC:
			begin
				fetch_hold_next = 1'b1;
				if (!ctx_busy_i)
				begin
					req_done_next   = 1'b1;
					fetch_hold_next = ctx_event_i;
					state_next      = ST_IDLE;
				end
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// The strap is sampled on the first edge after reset and never again.
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			endian_be_reg <= RESET_BE;
			cap_done_reg  <= 1'b0;
		end
		else if (!cap_done_reg)
		begin
			endian_be_reg <= big_endian_strap_i;
			cap_done_reg  <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg       <= ST_IDLE;
			fence_reg       <= 1'b0;
			out_cnt_reg     <= '0;
			req_done_reg    <= 1'b0;
			req_fault_reg   <= 1'b0;
			fault_hard_reg  <= 1'b0;
			req_rdata_reg   <= '0;
			issue_stall_reg <= 1'b0;
			pipe_flush_reg  <= 1'b0;
			fetch_hold_reg  <= 1'b0;
			bus_req_reg     <= 1'b0;
		end
		else
		begin
			state_reg       <= state_next;
			fence_reg       <= fence_next;
			out_cnt_reg     <= out_cnt_next;
			req_done_reg    <= req_done_next;
			req_fault_reg   <= req_fault_next;
			fault_hard_reg  <= fault_hard_next;
			req_rdata_reg   <= req_rdata_next;
			issue_stall_reg <= issue_stall_next;
			pipe_flush_reg  <= pipe_flush_next;
			fetch_hold_reg  <= fetch_hold_next;
			bus_req_reg     <= bus_req_next;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			op_reg        <= OP_NONMEM;
			size_reg      <= SZ_BYTE;
			ppb_reg       <= 1'b0;
			bus_we_reg    <= 1'b0;
			bus_addr_reg  <= '0;
			bus_size_reg  <= SZ_BYTE;
			bus_wdata_reg <= '0;
		end
		else if (take)
		begin
			op_reg        <= req_op_i;
			size_reg      <= req_size_i;
			ppb_reg       <= req_ppb_i;
			bus_we_reg    <= op_store;
			bus_addr_reg  <= req_addr_i;
			bus_size_reg  <= req_size_i;
			bus_wdata_reg <= wr_sw.dout;
		end
	end

	// Fetch data is never swapped and fetches are blocked while a barrier holds them.
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			fetch_ok_reg    <= 1'b0;
			fetch_fault_reg <= 1'b0;
			fetch_instr_reg <= '0;
		end
		else
		begin
			fetch_ok_reg    <= fetch_valid_i && !fetch_addr_i[ADDR_HALF_BIT] && !fetch_hold_reg;
			fetch_fault_reg <= fetch_valid_i && fetch_addr_i[ADDR_HALF_BIT];
			fetch_instr_reg <= fetch_rdata_i;
		end
	end

	assign endian_be_o   = endian_be_reg;
	assign req_done_o    = req_done_reg;
	assign req_fault_o   = req_fault_reg;
	assign fault_hard_o  = fault_hard_reg;
	assign req_rdata_o   = req_rdata_reg;
	assign issue_stall_o = issue_stall_reg;
	assign pipe_flush_o  = pipe_flush_reg;
	assign fetch_ok_o    = fetch_ok_reg;
	assign fetch_fault_o = fetch_fault_reg;
	assign fetch_hold_o  = fetch_hold_reg;
	assign fetch_instr_o = fetch_instr_reg;
	assign bus_req_o     = bus_req_reg;
	assign bus_we_o      = bus_we_reg;
	assign bus_addr_o    = bus_addr_reg;
	assign bus_size_o    = bus_size_reg;
	assign bus_wdata_o   = bus_wdata_reg;

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	order_fence_a : assert property ($rose(bus_req_reg) && $past(fence_reg) |-> $past(out_cnt_reg) == '0)
		else $error("Access issued past an order barrier with transfers outstanding.");
	nonmem_pass_a : assert property (take && req_op_i == OP_NONMEM |=> req_done_reg && !req_fault_reg)
		else $error("Non-memory instruction was held.");
	dcb_drain_a : assert property (req_done_reg && op_reg == OP_DATA_COMPLETION_BARRIER |-> $past(cnt_zero))
		else $error("Completion barrier ended with transfers outstanding.");
	dcb_stall_a : assert property (take && req_op_i == OP_DATA_COMPLETION_BARRIER |=> issue_stall_reg && !req_done_reg)
		else $error("Completion barrier did not stall issue.");
	sync_hold_a : assert property (fetch_hold_reg |=> !fetch_ok_reg)
		else $error("Fetch accepted while held by a barrier.");
	sync_flush_a : assert property (take && req_op_i == OP_FETCH_SYNC_BARRIER |=> pipe_flush_reg ##1 !pipe_flush_reg || $past(ctx_event_i))
		else $error("Sync barrier did not flush the pipeline.");
	ctx_settle_a : assert property (req_done_reg && op_reg == OP_FETCH_SYNC_BARRIER |-> !$past(ctx_busy_i))
		else $error("Sync barrier ended while a context change was settling.");
	ctx_event_a : assert property (ctx_event_i |=> pipe_flush_reg && fetch_hold_reg)
		else $error("Context event did not synchronise.");
	acq_block_a : assert property (state_reg == ST_RESP |-> !bus_req_reg && !req_done_reg)
		else $error("Load answer or new access before load data returned.");
	rel_order_a : assert property ($rose(bus_req_reg) && op_reg == OP_RELEASE_STORE |-> $past(out_cnt_reg) == '0)
		else $error("Release store issued with earlier accesses outstanding.");
	fetch_align_a : assert property (fetch_valid_i && fetch_addr_i[ADDR_HALF_BIT] |=> fetch_fault_reg && !fetch_ok_reg)
		else $error("Odd fetch address not faulted.");
	dev_align_a : assert property (take && op_mem && flt_device |=> req_fault_reg && !bus_req_reg)
		else $error("Unaligned device access not faulted.");
	trap_word_a : assert property (take && op_mem && flt_trap |=> req_fault_reg && !fault_hard_reg)
		else $error("Trapped unaligned word access not faulted.");
	be_lane_a : assert property (take && endian_be_reg && !req_ppb_i && req_size_i == SZ_WORD
		|=> bus_wdata_reg[BYTE_W-1:0] == $past(req_wdata_i[DATA_W-1 -: BYTE_W]))
		else $error("Big-endian word not byte reversed.");
	ppb_le_a : assert property (take && req_ppb_i |=> bus_wdata_reg == $past(req_wdata_i))
		else $error("Private peripheral bus data was swapped.");
	endian_fixed_a : assert property (cap_done_reg |=> $stable(endian_be_reg) && cap_done_reg)
		else $error("Byte order changed at run time.");
	fault_nobus_a : assert property (req_fault_reg |-> !bus_req_reg && state_reg == ST_IDLE)
		else $error("Faulting access reached the bus.");

endmodule : moau_core

// File: common/moau_pkg.sv
// Shared constants and types of the memory ordering and alignment unit.
package moau_pkg;

	localparam int   ADDR_W        = 32;
	localparam int   DATA_W        = 32;
	localparam int   BYTE_W        = 8;
	localparam int   BYTES_N       = DATA_W / BYTE_W;
	localparam int   HALF_BYTES    = 2;
	localparam int   ADDR_HALF_BIT = 0;
	localparam int   WORD_OFS_W    = 2;
	localparam int   OUT_CNT_W     = 4;
	localparam logic RESET_BE      = 1'b0;

	typedef enum logic [2:0]
	{
		OP_NONMEM                   = 3'h0,
		OP_LOAD                     = 3'h1,
		OP_STORE                    = 3'h2,
		OP_ACQUIRE_LOAD             = 3'h3,
		OP_RELEASE_STORE            = 3'h4,
		OP_DATA_ORDER_BARRIER       = 3'h5,
		OP_DATA_COMPLETION_BARRIER  = 3'h6,
		OP_FETCH_SYNC_BARRIER       = 3'h7
	} moau_op_e;

	typedef enum logic [1:0]
	{
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2
	} moau_size_e;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'h0,
		ST_DRAIN = 3'h1,
		ST_ISSUE = 3'h2,
		ST_RESP  = 3'h3,
		ST_SYNC  = 3'h4
	} moau_state_e;

endpackage : moau_pkg

// File: common/moau_swap_if.sv
// Signals between the core control and one byte-order converter.
interface moau_swap_if;
	import moau_pkg::*;

	logic                 swap_en;
	moau_size_e           size;
	logic [DATA_W-1:0]    din;
	logic [DATA_W-1:0]    dout;

	modport ctrl
	(
		output swap_en,
		output size,
		output din,
		input  dout
	);

	modport swapper
	(
		input  swap_en,
		input  size,
		input  din,
		output dout
	);

endinterface : moau_swap_if

// File: hdl/moau_byte_swap.sv
// Byte-order converter that reverses the bytes inside one access size.
module moau_byte_swap
	import moau_pkg::*;
(
	// Converter port.
	moau_swap_if.swapper sw
);

	logic [DATA_W-1:0] word_rev;
	logic [DATA_W-1:0] half_rev;

	always_comb
	begin
		word_rev = sw.din;
		half_rev = sw.din;
		for (int i = 0; i < BYTES_N; i++)
		begin
			word_rev[i*BYTE_W +: BYTE_W] = sw.din[(BYTES_N-1-i)*BYTE_W +: BYTE_W];
		end
		for (int i = 0; i < HALF_BYTES; i++)
		begin
			half_rev[i*BYTE_W +: BYTE_W] = sw.din[(HALF_BYTES-1-i)*BYTE_W +: BYTE_W];
		end
	end

	// Byte accesses never need reordering, so only wider sizes pick a reversed copy.
	assign sw.dout = !sw.swap_en           ? sw.din  :
	                 (sw.size == SZ_WORD)  ? word_rev :
	                 (sw.size == SZ_HALF)  ? half_rev : sw.din;

endmodule : moau_byte_swap

// File: tb/moau_bus_model.sv
// Behavioural memory bus partner that grants requests and answers after a set delay.
module moau_bus_model
(
	// Clock and reset.
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	// Bus side.
	input  wire logic        bus_req_i,
	output logic             bus_gnt_o,
	output logic             bus_rsp_o,
	output logic [31:0]      bus_rdata_o,
	// Control from the bench.
	input  wire logic [31:0] rd_val_i,
	input  wire logic [7:0]  rsp_dly_i
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [4:0] pend_reg;
	logic [7:0] wait_reg;
	logic       acc;
	logic       fire;

	assign acc  = bus_req_i && bus_gnt_o;
	assign fire = (pend_reg != 5'h00) && (wait_reg >= rsp_dly_i);

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			bus_gnt_o   <= 1'b0;
			bus_rsp_o   <= 1'b0;
			bus_rdata_o <= 32'h0;
			pend_reg    <= 5'h00;
			wait_reg    <= 8'h00;
		end
		else
		begin
			bus_gnt_o   <= bus_req_i && !bus_gnt_o;
			bus_rsp_o   <= fire;
			// Between answers the data lines toggle, so stale read data is never mistaken for fresh.
			bus_rdata_o <= fire ? rd_val_i : ~bus_rdata_o;
			pend_reg    <= pend_reg + 5'(acc) - 5'(fire);
			wait_reg    <= (fire || pend_reg == 5'h00) ? 8'h00 : wait_reg + 8'h01;
		end
	end
endmodule : moau_bus_model

// File: tb/moau_core_bench.sv
// Self-checking bench of the memory ordering and alignment unit.
module moau_core_bench import moau_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, rst, strap, trap, valid, dev, nord, private_periph_bus, busy, ev, fv, fence, be, r_f, r_h;
	logic        done, fault, hard, stall, flush, f_ok, f_flt, hold, gnt, rsp, breq, we, endian, c_we;
	moau_op_e    op;
	moau_size_e  size, bsize, c_sz;
	logic [31:0] addr, wdata, fa, frd, rdv, rdata, finstr, brd, baddr, bwd, lfsr, c_addr, c_wd;
	logic [7:0]  dly;
	int          n_mismatch, checks, n_gnt, n_rsp, n_flush, lat;

	moau_core moau_core_i
	(
		.core_clk_i(clk), .rst_i(rst), .big_endian_strap_i(strap), .unaligned_trap_bit_i(trap),
		.endian_be_o(endian), .req_valid_i(valid), .req_op_i(op), .req_size_i(size), .req_addr_i(addr),
		.req_wdata_i(wdata), .req_device_i(dev), .req_no_reorder_i(nord), .req_ppb_i(private_periph_bus),
		.req_done_o(done), .req_fault_o(fault), .fault_hard_o(hard), .req_rdata_o(rdata),
		.issue_stall_o(stall), .ctx_busy_i(busy), .ctx_event_i(ev), .pipe_flush_o(flush),
		.fetch_valid_i(fv), .fetch_addr_i(fa), .fetch_rdata_i(frd), .fetch_ok_o(f_ok),
		.fetch_fault_o(f_flt), .fetch_hold_o(hold), .fetch_instr_o(finstr), .bus_gnt_i(gnt),
		.bus_rsp_i(rsp), .bus_rdata_i(brd), .bus_req_o(breq), .bus_we_o(we), .bus_addr_o(baddr),
		.bus_size_o(bsize), .bus_wdata_o(bwd)
	);

	moau_bus_model moau_bus_model_i
	(
		.core_clk_i(clk), .rst_i(rst), .bus_req_i(breq), .bus_gnt_o(gnt), .bus_rsp_o(rsp),
		.bus_rdata_o(brd), .rd_val_i(rdv), .rsp_dly_i(dly)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt

	function automatic logic [31:0] swp(input logic b, input moau_size_e s, input logic [31:0] v);
		if (!b || s == SZ_BYTE)
			return v;
		if (s == SZ_HALF)
			return {v[31:16], v[7:0], v[15:8]};
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction : swp

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out;
		if (n_mismatch == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// Every access granted while a fence is armed must find all earlier transfers answered.
	always @(posedge clk)
	begin
		if (breq && gnt)
		begin
			if (fence)
				chk(n_rsp, n_gnt);
			fence = 1'b0;
			n_gnt++;
			c_addr = baddr;
			c_wd = bwd;
			c_we = we;
			c_sz = bsize;
		end
		if (rsp)
			n_rsp++;
		if (flush)
			n_flush++;
	end

	task automatic req(input moau_op_e o, input moau_size_e s, input logic [31:0] a, input logic [31:0] d,
		input logic dv, input logic pb);
		@(posedge clk);
		valid <= 1'b1;
		op <= o;
		size <= s;
		addr <= a;
		wdata <= d;
		dev <= dv;
		private_periph_bus <= pb;
		nord <= lfsr[7];
		lat = 0;
		do
		begin
			@(posedge clk);
			lat++;
		end
		while (done !== 1'b1 && lat < 300);
		valid <= 1'b0;
		r_f = fault;
		r_h = hard;
		if (lat >= 300)
			n_mismatch++;
	endtask : req

	task automatic flt(input moau_op_e o, input moau_size_e s, input logic [31:0] a, input logic dv, input logic e);
		int g0;
		g0 = n_gnt;
		req(o, s, a, 32'h3C, dv, 1'b0);
		chk(r_f, e);
		chk(r_h, 1'b0);
		chk(n_gnt - g0, !e);
	endtask : flt

	task automatic fetch(input logic [31:0] a, input logic ok);
		@(posedge clk);
		fv <= 1'b1;
		fa <= a;
		frd <= lfsr ^ a;
		@(posedge clk);
		fv <= 1'b0;
		@(posedge clk);
		chk(f_ok, ok);
		chk(f_flt, a[0]);
		chk(finstr, lfsr ^ a);
	endtask : fetch

	task automatic rnd;
		moau_size_e s;
		logic [31:0] a, d;
		logic p;
		lfsr = nxt(lfsr);
		s = lfsr[1] ? SZ_WORD : (lfsr[0] ? SZ_HALF : SZ_BYTE);
		a = {16'h0, lfsr[31:18], (s == SZ_WORD) ? 2'b00 : ((s == SZ_HALF) ? {lfsr[3], 1'b0} : lfsr[3:2])};
		d = (lfsr ^ 32'h5A5A5A5A) & (lfsr[1] ? 32'hFFFFFFFF : (lfsr[0] ? 32'hFFFF : 32'hFF));
		p = lfsr[6];
		rdv <= d;
		req(lfsr[4] ? OP_STORE : OP_LOAD, s, a, d, lfsr[5], p);
		chk(lfsr[4] ? c_wd : rdata, swp(be && !p, s, d));
		chk(c_addr, a);
		chk(c_we, lfsr[4]);
		chk(c_sz, s);
		chk(r_f, 1'b0);
	endtask : rnd

	task automatic do_reset(input logic s);
		rst <= 1'b1;
		strap <= s;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		strap <= !s;
		be = s;
		chk(endian, s);
	endtask : do_reset

	task automatic run_set;
		int g;
		trap <= 1'b0;
		dly <= 8'h0F;
		req(OP_STORE, SZ_WORD, 32'h2000, 32'hA5, 1'b0, 1'b0);
		req(OP_DATA_ORDER_BARRIER, SZ_WORD, 32'h0, 32'h0, 1'b0, 1'b0);
		chk(lat, 2);
		req(OP_NONMEM, SZ_WORD, 32'h0, 32'h0, 1'b0, 1'b0);
		chk(lat, 2);
		fence = 1'b1;
		req(OP_LOAD, SZ_WORD, 32'h2004, 32'h0, 1'b0, 1'b0);
		req(OP_STORE, SZ_BYTE, 32'h2008, 32'h7, 1'b0, 1'b0);
		fence = 1'b1;
		req(OP_RELEASE_STORE, SZ_WORD, 32'h200C, 32'h9, 1'b0, 1'b0);
		req(OP_ACQUIRE_LOAD, SZ_WORD, 32'h2010, 32'h0, 1'b0, 1'b0);
		fence = 1'b1;
		req(OP_STORE, SZ_WORD, 32'h2014, 32'h1, 1'b0, 1'b0);
		fork
			req(OP_DATA_COMPLETION_BARRIER, SZ_WORD, 32'h0, 32'h0, 1'b0, 1'b0);
			begin
				repeat (4) @(posedge clk);
				chk(stall, 1'b1);
			end
		join
		chk(n_rsp, n_gnt);
		chk(stall, 1'b0);
		trap <= 1'b1;
		flt(OP_LOAD, SZ_WORD, 32'h1001, 1'b1, 1'b1);
		flt(OP_STORE, SZ_BYTE, 32'h1003, 1'b1, 1'b0);
		flt(OP_ACQUIRE_LOAD, SZ_HALF, 32'h1001, 1'b0, 1'b1);
		flt(OP_RELEASE_STORE, SZ_HALF, 32'h1003, 1'b0, 1'b1);
		flt(OP_LOAD, SZ_WORD, 32'h1002, 1'b0, 1'b1);
		trap <= 1'b0;
		flt(OP_STORE, SZ_WORD, 32'h1002, 1'b0, 1'b0);
		busy <= 1'b1;
		g = n_flush;
		fork
			req(OP_FETCH_SYNC_BARRIER, SZ_WORD, 32'h0, 32'h0, 1'b0, 1'b0);
			begin
				repeat (3) @(posedge clk);
				fetch(32'h100, 1'b0);
				chk(hold, 1'b1);
				busy <= 1'b0;
			end
		join
		chk(n_flush - g, 1);
		chk(lat > 6, 1'b1);
		fetch(32'h102, 1'b1);
		fetch(32'h103, 1'b0);
		ev <= 1'b1;
		@(posedge clk);
		ev <= 1'b0;
		repeat (3) @(posedge clk);
		chk(n_flush - g, 2);
		req(OP_STORE, SZ_WORD, 32'hE000E100, 32'h1, 1'b0, 1'b1);
		req(OP_DATA_COMPLETION_BARRIER, SZ_WORD, 32'h0, 32'h0, 1'b0, 1'b0);
		chk(n_rsp, n_gnt);
		req(OP_FETCH_SYNC_BARRIER, SZ_WORD, 32'h0, 32'h0, 1'b0, 1'b0);
		chk(hold, 1'b0);
		rdv <= 32'h11223344;
		req(OP_LOAD, SZ_WORD, 32'hE000ED00, 32'h0, 1'b0, 1'b1);
		chk(rdata, 32'h11223344);
		req(OP_LOAD, SZ_WORD, 32'h3000, 32'h0, 1'b0, 1'b0);
		chk(rdata, be ? 32'h44332211 : 32'h11223344);
		dly <= 8'h00;
		repeat (40) rnd;
		repeat (40) @(posedge clk);
		chk(endian, be);
	endtask : run_set

	initial
	begin
		{rst, strap, trap, valid, dev, nord, private_periph_bus, busy, ev, fv, fence, be} = '0;
		op = OP_NONMEM;
		size = SZ_BYTE;
		{addr, wdata, fa, frd, rdv} = '0;
		dly = 8'h00;
		lfsr = 32'hD0C9;
		do_reset(1'b0);
		run_set;
		do_reset(1'b1);
		run_set;
		close_out;
	end

	// The run needs about a thousand cycles; anything far beyond that is a hang.
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out;
	end
endmodule : moau_core_bench
